// >>> emc_mode_control.sv
// Ejector operating-mode, keypad, vacuum control and info display logic with AXI4-Lite registers.
//
// Behaviour
// R1 - Power-up enters automatic mode, following external signals.
// R2 - Parameter writes accepted only in automatic mode.
// R3 - Both mode buttons held 3 s enter manual.
// R4 - Manual mode flashes switch-point and part LEDs.
// R5 - Brief both-button press leaves manual mode.
// R6 - External input change returns to automatic mode.
// R7 - Suction button toggles manual suction and LED.
// R8 - Blow button during suction blows while held.
// R9 - Held blow button drives blow and LED.
// R10 - Air saving applies limits in manual too.
// R11 - Switch/reset points regulate; part output hysteresis.
// R12 - Zero accepted within three percent, else error.
// R13 - Zero recalibrates only on yes.
// R14 - Nine digits shown as three pointed blocks.
// R15 - Info items are read-only counters and identities.
// R16 - Blow request overrides suction request.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module emc_mode_control #(
   parameter int          SENSOR_W   = 10,
   parameter int          FULL_SCALE = emc_pkg::FULL_SCALE_DEF,
   parameter int          HOLD_CYC   = emc_pkg::HOLD_CYC_DEF,
   parameter int          FLASH_CYC  = emc_pkg::FLASH_CYC_DEF,
   parameter logic [29:0] FIRMWARE   = 30'h0000_0101, // Value is arbitrary.
   parameter logic [29:0] PART_NUM   = 30'h0001_2345, // Value is arbitrary.
   parameter logic [29:0] SERIAL_NUM = 30'h0005_4321  // Value is arbitrary.
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   output      logic [1:0]            s_axi_bresp,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   output      logic [31:0]           s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire emc_pkg::emc_keys_t    keys,
   input  wire logic                  measure_screen,
   input  wire logic                  ext_suction,
   input  wire logic                  ext_blow,
   input  wire logic [SENSOR_W-1:0]   sensor_raw,
   output      logic                  suction_valve,
   output      logic                  blow_valve,
   output      logic                  part_present,
   output      emc_pkg::emc_leds_t    leds,
   output      logic [9:0]            disp_value,
   output      logic [2:0]            disp_point
);
   localparam logic [SENSOR_W-1:0] CAL_LIMIT =
      SENSOR_W'(FULL_SCALE * emc_pkg::CAL_LIMIT_PCT / emc_pkg::PCT_BASE);
   localparam logic [31:0] HOLD_LAST  = 32'(HOLD_CYC - 1);
   localparam logic [31:0] FLASH_LAST = 32'(FLASH_CYC - 1);

   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (d & m);
   endfunction : strb_merge

   function automatic logic [9:0] block_of(input logic [29:0] v, input logic [1:0] idx);
      logic [29:0] q;
      q = (idx == 2'h0) ? v / 30'(emc_pkg::BLOCK_BASE * emc_pkg::BLOCK_BASE) :
          (idx == 2'h1) ? v / 30'(emc_pkg::BLOCK_BASE) : v;
      return 10'(q % 30'(emc_pkg::BLOCK_BASE));
   endfunction : block_of

   emc_pkg::emc_mode_t mode_reg, mode_next;
   emc_pkg::emc_keys_t keys_reg;
   logic [31:0]         hold_reg, flash_cnt_reg;
   logic                flash_reg, armed_reg, man_suck_reg, pause_reg, part_reg;
   logic                ext_s_reg, ext_b_reg, cal_err_reg, energy_reg;
   logic [SENSOR_W-1:0] sp_reg, rp_reg, on_reg, off_reg, zero_reg;
   logic [29:0]         cnt1_reg, cnt2_reg;
   logic [2:0]          info_reg;
   logic [1:0]          block_reg;
   logic                aw_have_reg, w_have_reg;
   logic [7:0]          aw_addr_reg;
   logic [31:0]         w_data_reg;
   logic [3:0]          w_strb_reg;

   // Key edges and the manual mode entry and exit conditions.
   wire both      = keys.mode_a & keys.mode_b;
   wire both_rise = both & ~(keys_reg.mode_a & keys_reg.mode_b);
   wire suck_rise = keys.suction & ~keys_reg.suction & ~both;
   wire blow_rise = keys.blow & ~keys_reg.blow;
   wire next_rise = keys.next & ~keys_reg.next;
   wire manual    = (mode_reg == emc_pkg::EMC_MANUAL);
   wire hold_done = (hold_reg == HOLD_LAST);
   wire ext_chg   = (ext_suction != ext_s_reg) | (ext_blow != ext_b_reg);

   always_comb begin
      case (mode_reg)
         // The keys must still be held at the last count, or a release at that edge would enter.
         emc_pkg::EMC_AUTO:   mode_next = (hold_done & both & measure_screen) ? // R3
                                          emc_pkg::EMC_MANUAL : emc_pkg::EMC_AUTO;
         emc_pkg::EMC_MANUAL: mode_next = (ext_chg | (armed_reg & both_rise)) ? // R5 R6
                                          emc_pkg::EMC_AUTO : emc_pkg::EMC_MANUAL;
         default:             mode_next = emc_pkg::EMC_AUTO;
      endcase
   end

   // Vacuum relative to the calibrated zero, clamped at ambient.
   wire [SENSOR_W-1:0] vac = (sensor_raw > zero_reg) ? sensor_raw - zero_reg : '0;
   wire suck_req  = manual ? man_suck_reg : ext_suction;
   wire blow_req  = manual ? keys.blow : ext_blow; // R9
   wire pause_nxt = energy_reg & suck_req & ((vac >= sp_reg) | (pause_reg & (vac >= rp_reg))); // R10 R11
   wire suck_nxt  = suck_req & ~blow_req & ~pause_nxt; // R16
   wire part_nxt  = (vac >= on_reg) | (part_reg & (vac >= off_reg)); // R11

   // Register bus decode.
   wire wr_go    = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   wire wr_param = (aw_addr_reg == emc_pkg::ADDR_CTRL)   | (aw_addr_reg == emc_pkg::ADDR_SWITCH) |
                   (aw_addr_reg == emc_pkg::ADDR_RESET)  | (aw_addr_reg == emc_pkg::ADDR_PP_ON) |
                   (aw_addr_reg == emc_pkg::ADDR_PP_OFF) | (aw_addr_reg == emc_pkg::ADDR_ZERO);
   wire wr_other = (aw_addr_reg == emc_pkg::ADDR_STATUS) | (aw_addr_reg == emc_pkg::ADDR_INFO_SEL);
   wire wr_ok    = wr_go & ((wr_param & ~manual) | wr_other); // R2
   wire [31:0] wd = strb_merge(32'h0, w_data_reg, w_strb_reg);
   wire wr_zero  = wr_ok & (aw_addr_reg == emc_pkg::ADDR_ZERO) & wd[emc_pkg::BIT_YES]; // R13
   wire cal_fail = wr_zero & (sensor_raw > CAL_LIMIT); // R12
   wire err_clr  = wr_ok & (aw_addr_reg == emc_pkg::ADDR_STATUS) & wd[emc_pkg::BIT_CAL_ERR];
   wire ar_go    = s_axi_arvalid & s_axi_arready;

   wire [31:0] status_word = {27'h0, cal_err_reg, part_reg, blow_valve, suction_valve, manual};
   wire [29:0] info_val = (info_reg == emc_pkg::INFO_COUNT1)   ? cnt1_reg :
                          (info_reg == emc_pkg::INFO_COUNT2)   ? cnt2_reg :
                          (info_reg == emc_pkg::INFO_FIRMWARE) ? FIRMWARE :
                          (info_reg == emc_pkg::INFO_PART)     ? PART_NUM : SERIAL_NUM; // R15
   logic [31:0] rd_word;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         emc_pkg::ADDR_CTRL:     rd_word = {31'h0, energy_reg};
         emc_pkg::ADDR_SWITCH:   rd_word = 32'(sp_reg);
         emc_pkg::ADDR_RESET:    rd_word = 32'(rp_reg);
         emc_pkg::ADDR_PP_ON:    rd_word = 32'(on_reg);
         emc_pkg::ADDR_PP_OFF:   rd_word = 32'(off_reg);
         emc_pkg::ADDR_ZERO:     rd_word = 32'(zero_reg);
         emc_pkg::ADDR_STATUS:   rd_word = status_word;
         emc_pkg::ADDR_INFO_SEL: rd_word = {29'h0, info_reg};
         emc_pkg::ADDR_COUNT1:   rd_word = {2'h0, cnt1_reg};
         emc_pkg::ADDR_COUNT2:   rd_word = {2'h0, cnt2_reg};
         emc_pkg::ADDR_FIRMWARE: rd_word = {2'h0, FIRMWARE};
         emc_pkg::ADDR_PART:     rd_word = {2'h0, PART_NUM};
         emc_pkg::ADDR_SERIAL:   rd_word = {2'h0, SERIAL_NUM};
         default: begin
            rd_word = 32'h0;
            rd_hit  = 1'b0;
         end
      endcase
   end

   assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_reg & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   // AXI4-Lite slave: one write and one read in flight, refused writes answer SLVERR.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg  <= 1'b0;
         w_have_reg   <= 1'b0;
         aw_addr_reg  <= 8'h00;
         w_data_reg   <= 32'h0;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= emc_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= emc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? emc_pkg::RESP_OKAY : emc_pkg::RESP_SLVERR; // R2
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? emc_pkg::RESP_OKAY : emc_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Settings registers; parameter writes only land in automatic mode, info select and error clear writes land in either mode.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         energy_reg  <= 1'b0;
         sp_reg      <= '1;
         rp_reg      <= '0;
         on_reg      <= '1;
         off_reg     <= '0;
         zero_reg    <= '0;
         info_reg    <= emc_pkg::INFO_COUNT1;
         cal_err_reg <= 1'b0;
      end else begin
         if (wr_ok) begin
            case (aw_addr_reg)
               emc_pkg::ADDR_CTRL:     energy_reg <= wd[emc_pkg::BIT_ENABLE];
               emc_pkg::ADDR_SWITCH:   sp_reg     <= wd[SENSOR_W-1:0];
               emc_pkg::ADDR_RESET:    rp_reg     <= wd[SENSOR_W-1:0];
               emc_pkg::ADDR_PP_ON:    on_reg     <= wd[SENSOR_W-1:0];
               emc_pkg::ADDR_PP_OFF:   off_reg    <= wd[SENSOR_W-1:0];
               emc_pkg::ADDR_INFO_SEL: info_reg   <= wd[2:0];
               default:                info_reg   <= info_reg;
            endcase
         end
         if (wr_zero && !cal_fail) begin
            zero_reg <= sensor_raw; // R12 R13
         end
         // A failed calibration in the clearing cycle keeps the error set.
         cal_err_reg <= cal_fail | (cal_err_reg & ~err_clr); // R12
      end
   end

   // Mode, keypad and valve state.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg      <= emc_pkg::EMC_AUTO; // R1
         keys_reg      <= '0;
         ext_s_reg     <= 1'b0;
         ext_b_reg     <= 1'b0;
         hold_reg      <= 32'h0;
         armed_reg     <= 1'b0;
         man_suck_reg  <= 1'b0;
         pause_reg     <= 1'b0;
         part_reg      <= 1'b0;
         part_present  <= 1'b0;
         suction_valve <= 1'b0;
         blow_valve    <= 1'b0;
      end else begin
         mode_reg  <= mode_next;
         keys_reg  <= keys;
         ext_s_reg <= ext_suction;
         ext_b_reg <= ext_blow;
         hold_reg  <= (!manual && both && measure_screen && !hold_done) ? hold_reg + 32'h1 : 32'h0; // R3
         // Exit needs a fresh press, so the hold that entered manual mode cannot leave it.
         armed_reg <= manual & (armed_reg | ~both);
         if (!manual || mode_next != emc_pkg::EMC_MANUAL || blow_rise) begin
            man_suck_reg <= 1'b0; // R8
         end else if (suck_rise) begin
            man_suck_reg <= ~man_suck_reg; // R7
         end
         pause_reg     <= pause_nxt;
         part_reg      <= part_nxt;
         part_present  <= part_nxt; // R11
         suction_valve <= suck_nxt;
         blow_valve    <= blow_req; // R8 R9
      end
   end

   // Counters, flash timer and info display.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt1_reg      <= 30'h0;
         cnt2_reg      <= 30'h0;
         flash_cnt_reg <= 32'h0;
         flash_reg     <= 1'b0;
         block_reg     <= 2'h0;
      end else begin
         if (ext_suction && !ext_s_reg) cnt1_reg <= cnt1_reg + 30'h1;
         if (suck_nxt && !suction_valve) cnt2_reg <= cnt2_reg + 30'h1;
         flash_cnt_reg <= (!manual || flash_cnt_reg == FLASH_LAST) ? 32'h0 : flash_cnt_reg + 32'h1;
         if (!manual) flash_reg <= 1'b0;
         else if (flash_cnt_reg == FLASH_LAST) flash_reg <= ~flash_reg; // R4
         if (wr_ok && aw_addr_reg == emc_pkg::ADDR_INFO_SEL) block_reg <= 2'h0; // R14
         else if (next_rise) block_reg <= (block_reg == 2'(emc_pkg::BLOCKS - 1)) ? 2'h0 : block_reg + 2'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         disp_value <= 10'h0;
         disp_point <= 3'h0;
         leds       <= '0;
      end else begin
         disp_value <= block_of(info_val, block_reg); // R14
         disp_point <= 3'h4 >> block_reg;
         leds.switch_point <= manual ? flash_reg : pause_nxt; // R4
         leds.part_present <= manual ? flash_reg : part_nxt;
         leds.suction      <= suck_nxt; // R7
         leds.blow         <= blow_req; // R9
      end
   end

   // Checks.
   power_auto_a: assert property (@(posedge aclk) $rose(aresetn) |-> !manual) // R1
      else $error("mode not automatic after reset");
   param_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && wr_param && manual |=> s_axi_bresp == emc_pkg::RESP_SLVERR && $stable(sp_reg)) // R2
      else $error("parameter write accepted in manual mode");
   hold_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(manual) |-> $past(hold_reg) == HOLD_LAST) // R3
      else $error("manual entered without full hold");
   flash_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !manual ##1 !manual |-> !flash_reg) // R4
      else $error("indicator flashing outside manual mode");
   ext_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      manual && ext_chg |=> !manual) // R6
      else $error("external change did not leave manual mode");
   blow_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
      blow_valve |-> !suction_valve) // R16
      else $error("suction active during blow off");
   man_blow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      manual && keys.blow && mode_next == emc_pkg::EMC_MANUAL |=> blow_valve && leds.blow) // R9
      else $error("held blow key did not blow");
   cal_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_zero && sensor_raw > CAL_LIMIT |=> cal_err_reg && $stable(zero_reg)) // R12
      else $error("out of range zero accepted");
   block_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
      next_rise && block_reg == 2'h0 && !wr_ok |=> block_reg == 2'h1 ##1 disp_point == 3'h2) // R14
      else $error("display block order wrong");
endmodule : emc_mode_control

// >>> emc_mode_control_test.sv
// Self-checking testbench for the ejector mode control block.
`timescale 1ns/1ps
module emc_mode_control_test;
   // Short hold and flash counts keep the run brief.
   localparam int HC = 20;
   localparam int FC = 4;
   logic               aclk           = 1'h0;
   logic               aresetn        = 1'h0;
   logic [7:0]         s_axi_awaddr   = 8'h00;
   logic [7:0]         s_axi_araddr   = 8'h00;
   logic [31:0]        s_axi_wdata    = 32'h0;
   logic [3:0]         s_axi_wstrb    = 4'hf;
   logic               s_axi_awvalid  = 1'h0;
   logic               s_axi_wvalid   = 1'h0;
   logic               s_axi_bready   = 1'h0;
   logic               s_axi_arvalid  = 1'h0;
   logic               s_axi_rready   = 1'h0;
   logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic               s_axi_arready, s_axi_rvalid;
   logic [31:0]        s_axi_rdata;
   logic [1:0]         s_axi_bresp, s_axi_rresp;
   emc_pkg::emc_keys_t keys           = '0;
   logic               measure_screen = 1'h0;
   logic               cmd_suck       = 1'h0;
   logic               cmd_blow       = 1'h0;
   logic [9:0]         sensor_raw     = 10'h000;
   logic               ext_suction, ext_blow;
   logic               suction_valve, blow_valve, part_present;
   emc_pkg::emc_leds_t leds;
   logic [9:0]         disp_value;
   logic [2:0]         disp_point;
   logic [31:0]        rv;
   logic [31:0]        ex [4]         = '{32'h1000, 32'h958, 32'h761, 32'h1000};
   int                 fail_count     = 0;
   int                 n_compared     = 0;

   always #4 aclk = ~aclk;

   emc_mode_control #(.HOLD_CYC(HC), .FLASH_CYC(FC)) dut (.*);
   emc_sys_ctrl ctl (.*);

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'h0;
      w_done = 1'h0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_done = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_done = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      while (s_axi_bvalid !== 1'h1) @(posedge aclk);
      chk("bresp", 32'(s_axi_bresp), 32'(r));
      s_axi_bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      chk("rresp", 32'(s_axi_rresp), 32'(r));
      s_axi_rready <= 1'h0;
   endtask : rd

   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      rd(a, emc_pkg::RESP_OKAY, rv);
      chk(nm, rv, e);
   endtask : rc

   task automatic sb(input int b, input logic e);
      rd(emc_pkg::ADDR_STATUS, emc_pkg::RESP_OKAY, rv);
      chk("status", 32'(rv[b]), 32'(e));
   endtask : sb

   task automatic press(input emc_pkg::emc_keys_t k, input int n);
      keys <= k;
      tick(n);
      keys <= '0;
      tick(2);
   endtask : press

   // A stuck indicator either never lights or never goes dark within two periods.
   task automatic fl(input logic on);
      int s;
      s = 0;
      repeat (4 * FC) begin
         tick(1);
         s += int'(leds.switch_point) + int'(leds.part_present);
      end
      chk("flash", 32'(on ? (s > 0 && s < 8 * FC) : (s == 0)), 32'h1);
   endtask : fl

   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      $display("Watchdog expired");
      results();
   end

   initial begin
      tick(8);
      aresetn <= 1'h1;
      tick(1);
      rc("status", emc_pkg::ADDR_STATUS, 32'h0);
      cmd_suck <= 1'h1;
      tick(3);
      chk("suck", 32'(suction_valve), 32'h1);
      cmd_blow <= 1'h1;
      tick(3);
      chk("prio", 32'({suction_valve, blow_valve}), 32'h1);
      cmd_suck <= 1'h0;
      cmd_blow <= 1'h0;
      tick(3);
      $display("Test automatic follow done");
      wr(emc_pkg::ADDR_SWITCH, 32'h12c, emc_pkg::RESP_OKAY);
      rc("switch", emc_pkg::ADDR_SWITCH, 32'h12c);
      wr(emc_pkg::ADDR_RESET, 32'hc8, emc_pkg::RESP_OKAY);
      wr(emc_pkg::ADDR_PP_ON, 32'h1f4, emc_pkg::RESP_OKAY);
      wr(emc_pkg::ADDR_PP_OFF, 32'h190, emc_pkg::RESP_OKAY);
      wr(emc_pkg::ADDR_CTRL, 32'h1, emc_pkg::RESP_OKAY);
      wr(8'h40, 32'h1, emc_pkg::RESP_SLVERR);
      rd(8'h40, emc_pkg::RESP_SLVERR, rv);
      chk("unmapped", rv, 32'h0);
      sensor_raw <= 10'h208;
      tick(2);
      sb(3, 1'h1);
      chk("part_pin", 32'(part_present), 32'h1);
      sensor_raw <= 10'h1c2;
      tick(2);
      sb(3, 1'h1);
      sensor_raw <= 10'h186;
      tick(2);
      sb(3, 1'h0);
      chk("part_pin", 32'(part_present), 32'h0);
      sensor_raw <= 10'h064;
      $display("Test registers and part level done");
      measure_screen <= 1'h1;
      press(5'h18, 10);
      sb(0, 1'h0);
      press(5'h18, HC + 2);
      sb(0, 1'h1);
      wr(emc_pkg::ADDR_SWITCH, 32'h1, emc_pkg::RESP_SLVERR);
      rc("locked", emc_pkg::ADDR_SWITCH, 32'h12c);
      fl(1'h1);
      press(5'h04, 1);
      chk("msuck", 32'({suction_valve, leds.suction}), 32'h3);
      sensor_raw <= 10'h15e;
      tick(2);
      chk("pause", 32'(suction_valve), 32'h0);
      sensor_raw <= 10'h0fa;
      tick(2);
      chk("hold", 32'(suction_valve), 32'h0);
      sensor_raw <= 10'h096;
      tick(2);
      chk("resume", 32'(suction_valve), 32'h1);
      keys <= 5'h02;
      tick(2);
      chk("mblow", 32'({blow_valve, leds.blow, suction_valve}), 32'h6);
      keys <= '0;
      tick(2);
      chk("unblow", 32'({blow_valve, leds.blow}), 32'h0);
      press(5'h04, 1);
      chk("on", 32'(suction_valve), 32'h1);
      press(5'h04, 1);
      chk("off", 32'(suction_valve), 32'h0);
      press(5'h18, 1);
      sb(0, 1'h0);
      fl(1'h0);
      press(5'h18, HC + 2);
      sb(0, 1'h1);
      cmd_suck <= 1'h1;
      tick(3);
      sb(0, 1'h0);
      cmd_suck <= 1'h0;
      tick(3);
      $display("Test manual mode done");
      sensor_raw <= 10'h014;
      wr(emc_pkg::ADDR_ZERO, 32'h0, emc_pkg::RESP_OKAY);
      rc("zero", emc_pkg::ADDR_ZERO, 32'h0);
      wr(emc_pkg::ADDR_ZERO, 32'h1, emc_pkg::RESP_OKAY);
      rc("zero", emc_pkg::ADDR_ZERO, 32'h14);
      sensor_raw <= 10'h01e;
      wr(emc_pkg::ADDR_ZERO, 32'h1, emc_pkg::RESP_OKAY);
      rc("zero", emc_pkg::ADDR_ZERO, 32'h1e);
      sensor_raw <= 10'h01f;
      wr(emc_pkg::ADDR_ZERO, 32'h1, emc_pkg::RESP_OKAY);
      rc("zero", emc_pkg::ADDR_ZERO, 32'h1e);
      sb(4, 1'h1);
      wr(emc_pkg::ADDR_STATUS, 32'h10, emc_pkg::RESP_OKAY);
      sb(4, 1'h0);
      $display("Test calibration done");
      for (int i = 0; i < 5; i++) begin
         wr(emc_pkg::ADDR_INFO_SEL, 32'(i), emc_pkg::RESP_OKAY);
         tick(2);
         chk("point", 32'(disp_point), 32'h4);
      end
      for (int i = 0; i < 4; i++) begin
         chk("block", 32'({disp_point, disp_value}), ex[i]);
         press(5'h01, 1);
      end
      wr(emc_pkg::ADDR_COUNT1, 32'h0, emc_pkg::RESP_SLVERR);
      rc("firmware", emc_pkg::ADDR_FIRMWARE, 32'h101);
      rc("part", emc_pkg::ADDR_PART, 32'h12345);
      rc("serial", emc_pkg::ADDR_SERIAL, 32'h54321);
      // Two external suction pulses and five valve switch-ons happened above.
      rc("count1", emc_pkg::ADDR_COUNT1, 32'h2);
      rc("count2", emc_pkg::ADDR_COUNT2, 32'h5);
      $display("Test info display done");
      results();
   end
endmodule : emc_mode_control_test

// >>> emc_pkg.sv
// Package with constants, register map and carrier types for the ejector mode control.
package emc_pkg;
   localparam int CLK_KHZ        = 125000;
   localparam int HOLD_TIME_MS   = 3000;
   localparam int FLASH_TIME_MS  = 500;
   localparam int HOLD_CYC_DEF   = HOLD_TIME_MS * CLK_KHZ;
   localparam int FLASH_CYC_DEF  = FLASH_TIME_MS * CLK_KHZ;
   localparam int CAL_LIMIT_PCT  = 3;
   localparam int PCT_BASE       = 100;
   localparam int FULL_SCALE_DEF = 1000;
   localparam int BLOCK_BASE     = 1000;
   localparam int BLOCKS         = 3;

   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_SWITCH    = 8'h04;
   localparam logic [7:0] ADDR_RESET     = 8'h08;
   localparam logic [7:0] ADDR_PP_ON     = 8'h0c;
   localparam logic [7:0] ADDR_PP_OFF    = 8'h10;
   localparam logic [7:0] ADDR_ZERO      = 8'h14;
   localparam logic [7:0] ADDR_STATUS    = 8'h18;
   localparam logic [7:0] ADDR_INFO_SEL  = 8'h1c;
   localparam logic [7:0] ADDR_COUNT1    = 8'h20;
   localparam logic [7:0] ADDR_COUNT2    = 8'h24;
   localparam logic [7:0] ADDR_FIRMWARE  = 8'h28;
   localparam logic [7:0] ADDR_PART      = 8'h2c;
   localparam logic [7:0] ADDR_SERIAL    = 8'h30;

   localparam int BIT_MANUAL  = 0;
   localparam int BIT_SUCTION = 1;
   localparam int BIT_BLOW    = 2;
   localparam int BIT_PART    = 3;
   localparam int BIT_CAL_ERR = 4;
   localparam int BIT_ENABLE  = 0;
   localparam int BIT_YES     = 0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [2:0] INFO_COUNT1   = 3'h0;
   localparam logic [2:0] INFO_COUNT2   = 3'h1;
   localparam logic [2:0] INFO_FIRMWARE = 3'h2;
   localparam logic [2:0] INFO_PART     = 3'h3;
   localparam logic [2:0] INFO_SERIAL   = 3'h4;

   typedef enum logic [0:0] {
      EMC_AUTO   = 1'b0,
      EMC_MANUAL = 1'b1
   } emc_mode_t;

   typedef struct packed {
      logic mode_a;
      logic mode_b;
      logic suction;
      logic blow;
      logic next;
   } emc_keys_t;

   typedef struct packed {
      logic switch_point;
      logic part_present;
      logic suction;
      logic blow;
   } emc_leds_t;
endpackage : emc_pkg

// >>> emc_sys_ctrl.sv
// Behavioural model of the system controller that drives the ejector's external lines.
`timescale 1ns/1ps
module emc_sys_ctrl (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic cmd_suck,
   input  wire logic cmd_blow,
   output      logic ext_suction,
   output      logic ext_blow
);
   // Both lines may be high at once; the ejector must then resolve the conflict itself.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_suction <= 1'h0;
         ext_blow    <= 1'h0;
      end else begin
         ext_suction <= cmd_suck;
         ext_blow    <= cmd_blow;
      end
   end
endmodule : emc_sys_ctrl
